// file: burst_sram_pkg.sv
package burst_sram_pkg;

   // ************************************************************
   // Array and burst shape
   // ************************************************************
   localparam int WORD_W  = 18;
   localparam int ADDR_W  = 8;
   localparam int BURST_W = 2 * WORD_W;
   localparam int ENTRY_W = ADDR_W + BURST_W;
   localparam int MEM_N   = 1 << ADDR_W;

   // ************************************************************
   // Read latency, counted in output half-cycle events
   // ************************************************************
   localparam logic [1:0] LAT_LONG_HALF  = 2'h3;
   localparam logic [1:0] LAT_SHORT_HALF = 2'h2;
   localparam int         PIPE_N         = 4;

   // ************************************************************
   // Write buffer occupancy codes
   // ************************************************************
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_ONE   = 2'h1;
   localparam logic [1:0] BUF_FULL  = 2'h2;

   // ************************************************************
   // Bit positions inside the synchronised pin vector
   // ************************************************************
   localparam int SY_K      = 0;
   localparam int SY_KN     = 1;
   localparam int SY_C      = 2;
   localparam int SY_CN     = 3;
   localparam int SY_PLLDIS = 4;
   localparam int SY_SINGLE = 5;
   localparam int SY_RPS_N  = 6;
   localparam int SY_WPS_N  = 7;
   localparam int SY_ADDR   = 8;
   localparam int SY_DATA   = SY_ADDR + ADDR_W;
   localparam int SY_W      = SY_DATA + WORD_W;
   localparam int CLK_BITS  = 4;

endpackage

// file: ddr_burst_sram_port.sv
`timescale 1ns/1ps

module ddr_burst_sram_port (
   // Clock and reset.
   input  wire logic                              i_clk,
   input  wire logic                              i_sys_rst,
   // Input timing clock pair and output timing clock pair.
   input  wire logic                              i_k,
   input  wire logic                              i_k_n,
   input  wire logic                              i_c,
   input  wire logic                              i_c_n,
   // Static mode pins.
   input  wire logic                              i_pll_disable,
   input  wire logic                              i_single_clock,
   // Port selects, active low.
   input  wire logic                              i_read_port_select_n,
   input  wire logic                              i_write_port_select_n,
   // Shared address and write data.
   input  wire logic [burst_sram_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [burst_sram_pkg::WORD_W-1:0] i_wdata,
   // Read data and returned strobe pair.
   output logic      [burst_sram_pkg::WORD_W-1:0] o_rdata,
   output logic                                   o_rdata_valid,
   output logic                                   o_returned_strobe_pair,
   output logic                                   o_returned_strobe_pair_n,
   // Write buffer has room for one more burst.
   output logic                                   o_wr_ready
);

   // ************************************************************
   // Pin synchronisation and edge detection
   // ************************************************************
   logic [burst_sram_pkg::SY_W-1:0]     pins;
   logic [burst_sram_pkg::SY_W-1:0]     sy;
   logic [burst_sram_pkg::CLK_BITS-1:0] clk_prev_q;
   logic [burst_sram_pkg::CLK_BITS-1:0] clk_prev_d;
   logic                                k_rise;
   logic                                kn_rise;
   logic                                out_rise;
   logic                                out_rise_n;
   logic [burst_sram_pkg::ADDR_W-1:0]   s_addr;
   logic [burst_sram_pkg::WORD_W-1:0]   s_data;

   // Data and clocks share one synchroniser, so their skew is preserved.
   assign pins = {i_wdata, i_addr, i_write_port_select_n,
                  i_read_port_select_n, i_single_clock, i_pll_disable,
                  i_c_n, i_c, i_k_n, i_k};

   pin_sync #(
      .WIDTH (burst_sram_pkg::SY_W)
   ) u_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_pins    (pins),
      .o_sync    (sy)
   );

   assign s_addr = sy[burst_sram_pkg::SY_ADDR +: burst_sram_pkg::ADDR_W];
   assign s_data = sy[burst_sram_pkg::SY_DATA +: burst_sram_pkg::WORD_W];

   // Only rising edges of each clock of a pair are used.
   assign clk_prev_d = sy[burst_sram_pkg::CLK_BITS-1:0];
   assign k_rise  = sy[burst_sram_pkg::SY_K]  &&
                    !clk_prev_q[burst_sram_pkg::SY_K];
   assign kn_rise = sy[burst_sram_pkg::SY_KN] &&
                    !clk_prev_q[burst_sram_pkg::SY_KN];

   // Single-clock mode retimes read data on the input pair.
   always_comb begin
      if (sy[burst_sram_pkg::SY_SINGLE]) begin
         out_rise   = k_rise;
         out_rise_n = kn_rise;
      end else begin
         out_rise   = sy[burst_sram_pkg::SY_C] &&
                      !clk_prev_q[burst_sram_pkg::SY_C];
         out_rise_n = sy[burst_sram_pkg::SY_CN] &&
                      !clk_prev_q[burst_sram_pkg::SY_CN];
      end
   end

   // ************************************************************
   // Write capture into the two-entry buffer
   // ************************************************************
   logic                                 wr_armed_q;
   logic                                 wr_armed_d;
   logic [burst_sram_pkg::WORD_W-1:0]    wr_word0_q;
   logic [burst_sram_pkg::WORD_W-1:0]    wr_word0_d;
   logic                                 wr_push;
   logic [burst_sram_pkg::ENTRY_W-1:0]   wr_entry;
   logic                                 buf_out_valid;
   logic [burst_sram_pkg::ENTRY_W-1:0]   buf_head;
   logic [burst_sram_pkg::ENTRY_W-1:0]   slot0;
   logic [burst_sram_pkg::ENTRY_W-1:0]   slot1;
   logic [1:0]                           slot_valid;
   logic                                 wr_pop;
   logic                                 rd_fire;

   // Select and first word on the K rise, address and second word on
   // the twin rise; a burst completes only if the select was active.
   always_comb begin
      wr_armed_d = wr_armed_q;
      wr_word0_d = wr_word0_q;
      if (k_rise) begin
         wr_armed_d = !sy[burst_sram_pkg::SY_WPS_N];
         if (!sy[burst_sram_pkg::SY_WPS_N]) begin
            wr_word0_d = s_data;
         end
      end else if (kn_rise) begin
         wr_armed_d = 1'b0;
      end
   end

   assign wr_push  = kn_rise && wr_armed_q;
   assign wr_entry = {s_addr, s_data, wr_word0_q};

   // Edge history and the half-captured write burst.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clk_prev_q <= '0;
         wr_armed_q <= 1'b0;
         wr_word0_q <= '0;
      end else begin
         clk_prev_q <= clk_prev_d;
         wr_armed_q <= wr_armed_d;
         wr_word0_q <= wr_word0_d;
      end
   end

   // A full buffer refuses the burst; o_wr_ready tells the controller.
   two_entry_buffer #(
      .WIDTH (burst_sram_pkg::ENTRY_W)
   ) u_wbuf (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_in_valid   (wr_push),
      .i_in_data    (wr_entry),
      .o_in_ready   (o_wr_ready),
      .o_out_valid  (buf_out_valid),
      .o_out_data   (buf_head),
      .i_out_ready  (!rd_fire),
      .o_slot0      (slot0),
      .o_slot1      (slot1),
      .o_slot_valid (slot_valid)
   );

   // ************************************************************
   // Array with self-timed write and coherent read
   // ************************************************************
   logic [burst_sram_pkg::BURST_W-1:0] mem_q [burst_sram_pkg::MEM_N];
   logic [burst_sram_pkg::BURST_W-1:0] rd_burst;
   logic [burst_sram_pkg::ADDR_W-1:0]  head_addr;

   // The array has one access per cycle; a read wins and the write waits
   // in the buffer, which is why the buffer can really fill.
   assign rd_fire   = k_rise && !sy[burst_sram_pkg::SY_RPS_N];
   assign wr_pop    = buf_out_valid && !rd_fire;
   assign head_addr = buf_head[burst_sram_pkg::BURST_W +:
                               burst_sram_pkg::ADDR_W];

   // Newest buffered burst beats older one, and both beat the array.
   always_comb begin
      rd_burst = mem_q[s_addr];
      if (slot_valid[1] && slot1[burst_sram_pkg::BURST_W +:
                                 burst_sram_pkg::ADDR_W] == s_addr) begin
         rd_burst = slot1[burst_sram_pkg::BURST_W-1:0];
      end else if (slot_valid[0] && slot0[burst_sram_pkg::BURST_W +:
                                   burst_sram_pkg::ADDR_W] == s_addr) begin
         rd_burst = slot0[burst_sram_pkg::BURST_W-1:0];
      end
   end

   // The array holds no reset value, like any static memory.
   always_ff @(posedge i_clk) begin
      if (wr_pop) begin
         mem_q[head_addr] <= buf_head[burst_sram_pkg::BURST_W-1:0];
      end
   end

   // ************************************************************
   // Read latency pipeline and output registers
   // ************************************************************
   logic [burst_sram_pkg::WORD_W-1:0] pipe_w_q [burst_sram_pkg::PIPE_N];
   logic [burst_sram_pkg::WORD_W-1:0] pipe_w_d [burst_sram_pkg::PIPE_N];
   logic [burst_sram_pkg::PIPE_N-1:0] pipe_v_q;
   logic [burst_sram_pkg::PIPE_N-1:0] pipe_v_d;
   logic [1:0]                        lat;
   logic [burst_sram_pkg::WORD_W-1:0] rdata_d;
   logic                              rvalid_d;
   logic                              strobe_q;
   logic                              strobe_d;
   logic                              out_ev;

   assign out_ev = out_rise || out_rise_n;
   assign lat    = sy[burst_sram_pkg::SY_PLLDIS] ?
                   burst_sram_pkg::LAT_LONG_HALF :
                   burst_sram_pkg::LAT_SHORT_HALF;

   // Each output event shifts one half cycle; a new read drops its two
   // words so that the first leaves after lat events.
   always_comb begin
      pipe_w_d = pipe_w_q;
      pipe_v_d = pipe_v_q;
      rdata_d  = o_rdata;
      rvalid_d = o_rdata_valid;
      strobe_d = strobe_q;
      if (out_ev) begin
         rdata_d  = pipe_w_q[0];
         rvalid_d = pipe_v_q[0];
         strobe_d = out_rise;
         for (int i = 0; i < burst_sram_pkg::PIPE_N - 1; i++) begin
            pipe_w_d[i] = pipe_w_q[i+1];
            pipe_v_d[i] = pipe_v_q[i+1];
         end
         pipe_w_d[burst_sram_pkg::PIPE_N-1] = '0;
         pipe_v_d[burst_sram_pkg::PIPE_N-1] = 1'b0;
      end
      if (rd_fire) begin
         pipe_w_d[2'(lat - 2'h1)] = rd_burst[burst_sram_pkg::WORD_W-1:0];
         pipe_v_d[2'(lat - 2'h1)] = 1'b1;
         pipe_w_d[lat] = rd_burst[burst_sram_pkg::BURST_W-1:
                                  burst_sram_pkg::WORD_W];
         pipe_v_d[lat] = 1'b1;
      end
   end

   // Latency slots and output flops; only the array itself skips reset.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < burst_sram_pkg::PIPE_N; i++) begin
            pipe_w_q[i] <= '0;
         end
         pipe_v_q      <= '0;
         o_rdata       <= '0;
         o_rdata_valid <= 1'b0;
         strobe_q      <= 1'b0;
      end else begin
         pipe_w_q      <= pipe_w_d;
         pipe_v_q      <= pipe_v_d;
         o_rdata       <= rdata_d;
         o_rdata_valid <= rvalid_d;
         strobe_q      <= strobe_d;
      end
   end

   // The pair is taken from one flop, so its halves never disagree.
   assign o_returned_strobe_pair   = strobe_q;
   assign o_returned_strobe_pair_n = !strobe_q;

   // ************************************************************
   // Assertions and cover points
   // ************************************************************
   a_read_long_slots: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      rd_fire && sy[burst_sram_pkg::SY_PLLDIS]
      |=> pipe_v_q[2] && pipe_v_q[3])
      else $error("long latency read not placed three events out");

   a_read_short_slots: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      rd_fire && !sy[burst_sram_pkg::SY_PLLDIS]
      |=> pipe_v_q[1] && pipe_v_q[2])
      else $error("short latency read not placed two events out");

   a_addr_edges: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (rd_fire |-> k_rise) and (wr_push |-> kn_rise && !k_rise))
      else $error("address captured on the wrong clock edge");

   a_read_priority: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      rd_fire && buf_out_valid |=> buf_out_valid)
      else $error("write drained while a read held the array");

   a_output_timing: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (o_rdata != $past(o_rdata)) |-> $past(out_ev))
      else $error("read data moved without an output clock event");

   a_strobe_follows: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      out_rise |=> o_returned_strobe_pair && !o_returned_strobe_pair_n)
      else $error("returned strobe pair not aligned with data");

   a_write_commit: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      wr_pop |=> mem_q[$past(head_addr)] ==
                 $past(buf_head[burst_sram_pkg::BURST_W-1:0]))
      else $error("drained write did not reach the array");

   a_coherent_read: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      rd_fire && slot_valid[1] && slot1[burst_sram_pkg::BURST_W +:
                                 burst_sram_pkg::ADDR_W] == s_addr
      |-> rd_burst == slot1[burst_sram_pkg::BURST_W-1:0])
      else $error("read missed the newest pending write");

   a_select_gates: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      k_rise && sy[burst_sram_pkg::SY_WPS_N] |=> !wr_armed_q)
      else $error("write started with its select inactive");

   c_read_long: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_fire && sy[burst_sram_pkg::SY_PLLDIS]);
   c_read_short: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_fire && !sy[burst_sram_pkg::SY_PLLDIS]);
   c_write_pushed: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_push);
   c_buffer_full: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      !o_wr_ready);

endmodule

// file: pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // Raw pins and their synchronised copy.
   input  wire logic [WIDTH-1:0] i_pins,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_d = i_pins;
      sync_d = meta_q;
   end

   // Two flops for every pin, all cleared by reset.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q;

endmodule

// file: sram_host_model.sv
`timescale 1ns/1ps

module sram_host_model (
   // Pacing clock and clock-mode strap.
   input  wire logic                              i_clk,
   input  wire logic                              i_single_clock,
   // Timing clock pairs driven toward the memory.
   output logic                                   o_k,
   output logic                                   o_k_n,
   output logic                                   o_c,
   output logic                                   o_c_n,
   // Selects, shared address and write data.
   output logic                                   o_read_port_select_n,
   output logic                                   o_write_port_select_n,
   output logic      [burst_sram_pkg::ADDR_W-1:0] o_addr,
   output logic      [burst_sram_pkg::WORD_W-1:0] o_wdata
);
   // ************************************************************
   // Controller side of one input clock cycle
   // ************************************************************
   realtime rise_t;

   // The pins start idle with both selects released.
   initial begin
      o_k = 1'b0;
      o_k_n = 1'b1;
      o_read_port_select_n = 1'b1;
      o_write_port_select_n = 1'b1;
      o_addr = '0;
      o_wdata = '0;
      rise_t = 0.0;
   end

   // The output pair tracks the input pair; single-clock mode parks it.
   always_comb begin
      o_c = i_single_clock ? 1'b1 : o_k;
      o_c_n = i_single_clock ? 1'b1 : o_k_n;
   end

   // One 200 ns cycle: read address on the rise, write address on the twin.
   task automatic kcycle(input logic rd, input logic [7:0] ra,
                         input logic wr, input logic [7:0] wa,
                         input logic [17:0] w0, input logic [17:0] w1);
      @(posedge i_clk);
      #2;
      o_addr = ra;
      o_wdata = w0;
      o_read_port_select_n = !rd;
      o_write_port_select_n = !wr;
      @(posedge i_clk);
      #2;
      o_k = 1'b1;
      o_k_n = 1'b0;
      rise_t = $realtime;
      repeat (3) @(posedge i_clk);
      #2;
      // Selects are only sampled on the rise, so they are released here.
      o_addr = wa;
      o_wdata = w1;
      o_read_port_select_n = 1'b1;
      o_write_port_select_n = 1'b1;
      @(posedge i_clk);
      #2;
      o_k = 1'b0;
      o_k_n = 1'b1;
      repeat (2) @(posedge i_clk);
      #2;
   endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
   end \
end

module testbench;
   // ************************************************************
   // Signals, reference memory and expectation queues
   // ************************************************************
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        pll = 1'b1;
   logic        single = 1'b0;
   logic        k, k_n, c, c_n, rps_n, wps_n;
   logic [7:0]  addr;
   logic [17:0] wdata, o_rdata;
   logic        o_rdata_valid, strobe, strobe_n, o_wr_ready;
   logic        prev_strobe = 1'b0;
   int          err_count = 0;
   int          cmp_count = 0;
   int          seed = 26;
   int          cycles = 0;
   logic [35:0] ref_mem [256];
   logic [17:0] exp_word [$];
   int          exp_ev [$];
   realtime     exp_t [$];

   // The system clock runs at 40 MHz.
   always #12.5 i_clk = ~i_clk;

   sram_host_model sram_host_model_i (
      .i_clk                 (i_clk),
      .i_single_clock        (single),
      .o_k                   (k),
      .o_k_n                 (k_n),
      .o_c                   (c),
      .o_c_n                 (c_n),
      .o_read_port_select_n  (rps_n),
      .o_write_port_select_n (wps_n),
      .o_addr                (addr),
      .o_wdata               (wdata)
   );

   ddr_burst_sram_port ddr_burst_sram_port_i (
      .i_clk                    (i_clk),
      .i_sys_rst                (i_sys_rst),
      .i_k                      (k),
      .i_k_n                    (k_n),
      .i_c                      (c),
      .i_c_n                    (c_n),
      .i_pll_disable            (pll),
      .i_single_clock           (single),
      .i_read_port_select_n     (rps_n),
      .i_write_port_select_n    (wps_n),
      .i_addr                   (addr),
      .i_wdata                  (wdata),
      .o_rdata                  (o_rdata),
      .o_rdata_valid            (o_rdata_valid),
      .o_returned_strobe_pair   (strobe),
      .o_returned_strobe_pair_n (strobe_n),
      .o_wr_ready               (o_wr_ready)
   );

   // Prints the counts and the verdict, then stops the run.
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // A hang is cut short well past the expected run of about 510 cycles.
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         finish_test();
      end
   end

   // Runs one input cycle and notes the two read words it should return.
   task automatic access(input logic rd, input logic [7:0] ra,
                         input logic wr, input logic [7:0] wa,
                         input logic [17:0] w0, input logic [17:0] w1);
      logic [17:0] e0, e1;
      int          lat;
      lat = pll ? 3 : 2;
      {e1, e0} = ref_mem[ra];
      sram_host_model_i.kcycle(rd, ra, wr, wa, w0, w1);
      if (rd) begin
         exp_word.push_back(e0);
         exp_ev.push_back(lat);
         exp_t.push_back(sram_host_model_i.rise_t);
         exp_word.push_back(e1);
         exp_ev.push_back(lat + 1);
         exp_t.push_back(sram_host_model_i.rise_t);
      end
      if (wr) begin
         ref_mem[wa] = {w1, w0};
         `CHECK(o_wr_ready, 1'b1)
      end
   endtask

   // An idle cycle still puts random address and data on the pins.
   task automatic idle;
      access(1'b0, 8'($random(seed)), 1'b0, 8'($random(seed)),
             18'($random(seed)), 18'($random(seed)));
   endtask

   // Each strobe step with valid data is one word; its half-cycle index
   // since the capturing rise must match the chosen latency.
   always @(negedge i_clk) begin
      logic [17:0] ew;
      int          ev, got_ev;
      realtime     t;
      if (!i_sys_rst) begin
         `CHECK(strobe_n, ~strobe)
         if (o_rdata_valid === 1'b1 && strobe !== prev_strobe) begin
            if (exp_word.size() == 0) begin
               err_count++;
               $display("mismatch at %0t: got %0h expected %0h",
                        $time, o_rdata, 18'h0);
            end else begin
               ew = exp_word.pop_front();
               ev = exp_ev.pop_front();
               t = exp_t.pop_front();
               got_ev = $rtoi(($realtime - t - 25.0) / 100.0);
               `CHECK(o_rdata, ew)
               `CHECK(got_ev, ev)
               `CHECK(strobe, ev % 2 == 0)
            end
         end
      end
      prev_strobe = strobe;
   end

   // ************************************************************
   // Main sequence: three clocking modes with mixed traffic
   // ************************************************************
   initial begin
      logic [31:0] r;
      logic [7:0]  wa, ra;
      logic        rd, wr;
      repeat (6) @(posedge i_clk);
      #2;
      `CHECK(o_rdata_valid, 1'b0)
      `CHECK(strobe_n, 1'b1)
      `CHECK(o_wr_ready, 1'b1)
      i_sys_rst = 1'b0;
      for (int m = 0; m < 3; m++) begin
         repeat (3) idle();
         pll = (m != 1);
         single = (m == 2);
         idle();
         for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            wr = (i < 4) | r[2];
            rd = (i > 0) & r[3];
            wa = 8'(m * 4 + ((i < 4) ? i : r[1:0]));
            ra = 8'(m * 4 + ((i > 3) ? r[5:4] : i - 1));
            access(rd, ra, wr, wa, 18'($random(seed)), 18'($random(seed)));
         end
      end
      repeat (3) idle();
      `CHECK(exp_word.size(), 0)
      finish_test();
   end
endmodule

// file: two_entry_buffer.sv
`timescale 1ns/1ps

module two_entry_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // Filling side.
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Draining side.
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready,
   // Snoop view: slot 0 is oldest, slot 1 newest.
   output logic      [WIDTH-1:0] o_slot0,
   output logic      [WIDTH-1:0] o_slot1,
   output logic      [1:0]       o_slot_valid
);

   logic [WIDTH-1:0] slot0_q;
   logic [WIDTH-1:0] slot0_d;
   logic [WIDTH-1:0] slot1_q;
   logic [WIDTH-1:0] slot1_d;
   logic [1:0]       cnt_q;
   logic [1:0]       cnt_d;
   logic             push;
   logic             pop;

   // Ready ignores a same-cycle pop so no path runs from drain to fill.
   assign o_in_ready  = (cnt_q != burst_sram_pkg::BUF_FULL);
   assign o_out_valid = (cnt_q != burst_sram_pkg::BUF_EMPTY);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Pop shifts the newer slot down, then push lands in the first free one.
   always_comb begin
      slot0_d = slot0_q;
      slot1_d = slot1_q;
      cnt_d   = cnt_q;
      if (pop) begin
         slot0_d = slot1_q;
         cnt_d   = 2'(cnt_d - burst_sram_pkg::BUF_ONE);
      end
      if (push) begin
         if (cnt_d == burst_sram_pkg::BUF_EMPTY) begin
            slot0_d = i_in_data;
         end else begin
            slot1_d = i_in_data;
         end
         cnt_d = 2'(cnt_d + burst_sram_pkg::BUF_ONE);
      end
   end

   // Occupancy and slot storage.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         slot0_q <= '0;
         slot1_q <= '0;
         cnt_q   <= burst_sram_pkg::BUF_EMPTY;
      end else begin
         slot0_q <= slot0_d;
         slot1_q <= slot1_d;
         cnt_q   <= cnt_d;
      end
   end

   assign o_out_data      = slot0_q;
   assign o_slot0         = slot0_q;
   assign o_slot1         = slot1_q;
   assign o_slot_valid[0] = (cnt_q != burst_sram_pkg::BUF_EMPTY);
   assign o_slot_valid[1] = (cnt_q == burst_sram_pkg::BUF_FULL);

endmodule
